// ---- fuch_pkg.sv ----
package fuch_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CDB_LO = 8'h00;
  localparam logic [7:0] OFS_CDB_HI = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_PARAM = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_SENSE = 8'h14;
  localparam logic [7:0] OFS_REASSIGN = 8'h18;
  localparam logic [7:0] OFS_QUERY = 8'h1c;
  localparam logic [7:0] OFS_PROGRESS = 8'h20;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RESERVED = 1;
  localparam int CTRL_EXTENT = 2;

  // ----------------------------------------------------------------
  // command block layout (byte 0 in bits 7:0)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_FORMAT = 8'h04;
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  localparam logic [7:0] OP_REQ_SENSE = 8'h03;
  localparam int CDB_FORMAT_DATA_PRESENT = 12;
  localparam int CDB_COMPLETE_LIST_FLAG = 11;
  localparam int CDB_LISTFMT_LSB = 8;

  // ----------------------------------------------------------------
  // parameter list header option bits
  // ----------------------------------------------------------------
  localparam int OPT_OPTIONS_VALID = 7;
  localparam int OPT_SKIP_PRIMARY = 6;
  localparam int OPT_SKIP_CERTIFY = 5;
  localparam int OPT_HALT = 4;
  localparam logic [7:0] OPT_SUPPORTED = 8'hf0;
  localparam logic [2:0] HDR_LAST = 3'h7;

  // ----------------------------------------------------------------
  // status and sense codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_CONFLICT = 8'h18;
  localparam logic [3:0] KEY_NONE = 4'h0;
  localparam logic [3:0] KEY_NOT_READY = 4'h2;
  localparam logic [3:0] KEY_MEDIUM = 4'h3;
  localparam logic [3:0] KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NOT_READY = 8'h04;
  localparam logic [7:0] ASCQ_FMT = 8'h04;
  localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
  localparam logic [7:0] ASC_CDB_FIELD = 8'h24;
  localparam logic [7:0] ASC_PARAM_FIELD = 8'h26;
  localparam logic [7:0] ASC_NO_SPARE = 8'h32;

  // ----------------------------------------------------------------
  // medium and defect lists
  // ----------------------------------------------------------------
  localparam int BLK_W = 6;
  localparam logic [BLK_W-1:0] BLK_LAST = 6'h3f;
  localparam int GLIST_DEPTH = 16;
  localparam int GLIST_CW = 5;
  localparam int PLIST_DEPTH = 4;
  localparam logic [PLIST_DEPTH-1:0][31:0] PLIST = {32'h0000_0005, 32'h0000_0011, 32'h0000_0028, 32'h0000_003e};

  typedef enum logic [2:0] {
    FUCH_IDLE,
    FUCH_DOUT_HDR,
    FUCH_DOUT_PAT,
    FUCH_DOUT_LIST,
    FUCH_FORMAT
  } fuch_state_t;

endpackage : fuch_pkg

// ---- fuch_glist.sv ----
module fuch_glist (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic add,
  input wire logic [31:0] add_lba,
  input wire logic [31:0] query_lba,
  output logic full,
  output logic [fuch_pkg::GLIST_CW-1:0] count,
  output logic query_hit,
  output logic add_dup
);
  import fuch_pkg::*;

  typedef struct packed {
    logic [GLIST_DEPTH-1:0][31:0] entry;
    logic [GLIST_CW-1:0] count;
  } fuch_glist_t;

  fuch_glist_t r;
  fuch_glist_t next_r;
  logic [GLIST_DEPTH-1:0] q_vec;
  logic [GLIST_DEPTH-1:0] d_vec;

  // ----------------------------------------------------------------
  // match only filled entries
  // ----------------------------------------------------------------
  for (genvar i = 0; i < GLIST_DEPTH; i++) begin : g_match
    assign q_vec[i] = (GLIST_CW'(i) < r.count) && (r.entry[i] == query_lba);
    assign d_vec[i] = (GLIST_CW'(i) < r.count) && (r.entry[i] == add_lba);
  end

  assign query_hit = |q_vec;
  assign add_dup = |d_vec;
  assign full = (r.count == GLIST_CW'(GLIST_DEPTH));
  assign count = r.count;

  always_comb begin
    next_r = r;
    if (clr) begin
      next_r.count = '0;
    end else if (add && !add_dup && !full) begin
      // duplicates merge silently so a location is listed once
      next_r.entry[r.count[GLIST_CW-2:0]] = add_lba;
      next_r.count = r.count + GLIST_CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule : fuch_glist

// ---- fuch_format_unit.sv ----
// Implementation choices: the APB register port and the placing of the registers.
module fuch_format_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fuch_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic certify_fail,
  output logic format_busy
);
  import fuch_pkg::*;

  typedef struct packed {
    fuch_state_t fsm;
    logic [47:0] cdb;
    logic reserved_lun;
    logic extent_held;
    logic [2:0] hdr_idx;
    logic [7:0] opts;
    logic [15:0] list_len;
    logic [15:0] rem;
    logic [1:0] desc_idx;
    logic [23:0] desc_sh;
    logic [BLK_W-1:0] block;
    logic [7:0] status;
    logic [3:0] sense_key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [15:0] sks;
    logic done;
    logic inquiry_ok;
    logic fmt_err;
    logic [31:0] query_lba;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy;
  } fuch_regs_t;

  fuch_regs_t r;
  fuch_regs_t next_r;
  logic glist_clr;
  logic glist_add;
  logic [31:0] glist_lba;
  logic glist_full;
  logic glist_dup;
  logic glist_hit;
  logic [GLIST_CW-1:0] glist_count;
  logic [PLIST_DEPTH-1:0] pl_blk_vec;
  logic [PLIST_DEPTH-1:0] pl_q_vec;
  logic pl_blk_hit;
  logic pl_q_hit;
  logic setup;
  logic wr;
  logic go_now;
  logic param_wr;
  logic conflict;
  logic [7:0] opcode;
  logic [7:0] pbyte;
  logic [15:0] progress;
  logic err_now;
  logic cert_now;

  // ----------------------------------------------------------------
  // primary list: constant table, never written
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PLIST_DEPTH; i++) begin : g_plist
    assign pl_blk_vec[i] = (PLIST[i] == {{(32 - BLK_W){1'b0}}, r.block});
    assign pl_q_vec[i] = (PLIST[i] == r.query_lba);
  end
  assign pl_blk_hit = |pl_blk_vec;
  assign pl_q_hit = |pl_q_vec;

  fuch_glist u_glist (
    .pclk(pclk),
    .presetn(presetn),
    .clr(glist_clr),
    .add(glist_add),
    .add_lba(glist_lba),
    .query_lba(r.query_lba),
    .full(glist_full),
    .count(glist_count),
    .query_hit(glist_hit),
    .add_dup(glist_dup)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr = psel && penable && r.pready && pwrite;
  assign go_now = wr && (paddr == OFS_CTRL) && pwdata[CTRL_GO];
  assign param_wr = wr && (paddr == OFS_PARAM);
  assign conflict = pwdata[CTRL_RESERVED] || pwdata[CTRL_EXTENT];
  assign opcode = r.cdb[7:0];
  assign pbyte = pwdata[7:0];
  assign progress = {r.block, 10'h000};
  assign cert_now = (r.fsm == FUCH_FORMAT) && certify_fail && !r.opts[OPT_SKIP_CERTIFY]
                    && !(pl_blk_hit && !r.opts[OPT_SKIP_PRIMARY]);
  assign err_now = glist_add && glist_full && !glist_dup && r.opts[OPT_HALT];

  function automatic fuch_regs_t start_fmt(input fuch_regs_t s);
    fuch_regs_t t;
    t = s;
    t.fsm = FUCH_FORMAT;
    t.busy = 1'b1;
    t.block = '0;
    t.status = ST_GOOD;
    t.sense_key = KEY_NOT_READY;
    t.asc = ASC_NOT_READY;
    t.ascq = ASCQ_FMT;
    return t;
  endfunction : start_fmt

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    glist_clr = 1'b0;
    glist_add = 1'b0;
    glist_lba = '0;
    next_r.pready = setup;
    if (setup) begin
      next_r.pslverr = 1'b0;
      unique case (paddr)
        OFS_CDB_LO: next_r.prdata = r.cdb[31:0];
        OFS_CDB_HI: next_r.prdata = {16'h0000, r.cdb[47:32]};
        OFS_CTRL: next_r.prdata = {29'h0000_0000, r.extent_held, r.reserved_lun, 1'b0};
        OFS_STATUS: next_r.prdata = {progress, 4'h0, (r.fsm inside {FUCH_DOUT_HDR, FUCH_DOUT_PAT, FUCH_DOUT_LIST}),
                                     r.inquiry_ok, r.done, r.busy, r.status};
        OFS_SENSE: next_r.prdata = {8'h00, r.ascq, r.asc, 4'h0, r.sense_key};
        OFS_QUERY: next_r.prdata = {19'h0_0000, glist_count, 7'h00, glist_hit || pl_q_hit};
        OFS_PROGRESS: next_r.prdata = {16'h0000, r.sks};
        OFS_PARAM, OFS_REASSIGN: next_r.prdata = '0;
        default: begin
          // unmapped offsets answer with an error and zero data
          next_r.prdata = '0;
          next_r.pslverr = 1'b1;
        end
      endcase
    end

    // format engine, one block per clock
    if (r.fsm == FUCH_FORMAT) begin
      next_r.block = r.block + BLK_W'(1);
      if (cert_now) begin
        glist_add = 1'b1;
        glist_lba = {{(32 - BLK_W){1'b0}}, r.block};
      end
      if (err_now) begin
        next_r.fmt_err = 1'b1;
      end
      if (r.block == BLK_LAST) begin
        next_r.fsm = FUCH_IDLE;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        if (r.fmt_err || err_now) begin
          next_r.status = ST_CHECK;
          next_r.sense_key = KEY_MEDIUM;
          next_r.asc = ASC_NO_SPARE;
          next_r.ascq = 8'h00;
        end else begin
          next_r.status = ST_GOOD;
          next_r.sense_key = KEY_NONE;
          next_r.asc = 8'h00;
          next_r.ascq = 8'h00;
        end
      end
    end

    if (wr) begin
      unique case (paddr)
        OFS_CDB_LO: begin
          if (!(r.fsm inside {FUCH_DOUT_HDR, FUCH_DOUT_PAT, FUCH_DOUT_LIST})) begin
            next_r.cdb[31:0] = pwdata;
          end
        end
        OFS_CDB_HI: begin
          if (!(r.fsm inside {FUCH_DOUT_HDR, FUCH_DOUT_PAT, FUCH_DOUT_LIST})) begin
            next_r.cdb[47:32] = pwdata[15:0];
          end
        end
        OFS_CTRL: begin
          next_r.reserved_lun = pwdata[CTRL_RESERVED];
          next_r.extent_held = pwdata[CTRL_EXTENT];
        end
        OFS_REASSIGN: begin
          // reassigned blocks only while idle, so adds never collide
          if (r.fsm == FUCH_IDLE) begin
            glist_add = 1'b1;
            glist_lba = pwdata;
          end
        end
        OFS_QUERY: next_r.query_lba = pwdata;
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // command start
    // ----------------------------------------------------------------
    if (go_now) begin
      unique case (r.fsm)
        FUCH_IDLE: begin
          next_r.done = 1'b1;
          next_r.inquiry_ok = 1'b0;
          next_r.status = ST_GOOD;
          if (opcode == OP_FORMAT) begin
            next_r.fmt_err = 1'b0;
            if (conflict) begin
              next_r.status = ST_CONFLICT;
            end else if (r.cdb[CDB_FORMAT_DATA_PRESENT]) begin
              next_r.done = 1'b0;
              next_r.fsm = FUCH_DOUT_HDR;
              next_r.hdr_idx = '0;
              next_r.busy = 1'b1;
            end else begin
              next_r.done = 1'b0;
              next_r = start_fmt(next_r);
              next_r.opts = '0;
            end
          end else if (opcode == OP_INQUIRY) begin
            next_r.inquiry_ok = 1'b1;
          end else if (opcode != OP_REQ_SENSE) begin
            next_r.status = ST_CHECK;
            next_r.sense_key = KEY_ILLEGAL;
            next_r.asc = ASC_BAD_OPCODE;
            next_r.ascq = 8'h00;
          end
        end
        FUCH_FORMAT: begin
          next_r.done = 1'b1;
          next_r.inquiry_ok = 1'b0;
          if (opcode == OP_INQUIRY) begin
            next_r.status = ST_GOOD;
            next_r.inquiry_ok = 1'b1;
          end else if (opcode == OP_REQ_SENSE) begin
            next_r.status = ST_GOOD;
            next_r.sks = progress;
            if (r.fmt_err || err_now) begin
              next_r.sense_key = KEY_MEDIUM;
              next_r.asc = ASC_NO_SPARE;
              next_r.ascq = 8'h00;
            end else begin
              next_r.sense_key = KEY_NOT_READY;
              next_r.asc = ASC_NOT_READY;
              next_r.ascq = ASCQ_FMT;
            end
          end else begin
            next_r.status = conflict ? ST_CONFLICT : ST_CHECK;
          end
        end
        FUCH_DOUT_HDR, FUCH_DOUT_PAT, FUCH_DOUT_LIST: begin
          // a new command during data-out is dropped
        end
      endcase
    end

    // ----------------------------------------------------------------
    // parameter list intake, one byte per write
    // ----------------------------------------------------------------
    if (param_wr) begin
      unique case (r.fsm)
        FUCH_DOUT_HDR: begin
          next_r.hdr_idx = r.hdr_idx + 3'h1;
          unique case (r.hdr_idx)
            3'h1: next_r.opts = pbyte;
            3'h2: next_r.list_len[15:8] = pbyte;
            3'h3: begin
              next_r.list_len[7:0] = pbyte;
              if (((r.opts & ~OPT_SUPPORTED) != 8'h00)
                  || (!r.opts[OPT_OPTIONS_VALID] && (r.opts[6:4] != 3'h0))) begin
                next_r.fsm = FUCH_IDLE;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.status = ST_CHECK;
                next_r.sense_key = KEY_ILLEGAL;
                next_r.asc = ASC_PARAM_FIELD;
                next_r.ascq = 8'h00;
              end else if ((r.cdb[CDB_LISTFMT_LSB +: 3] != 3'h0) && ({r.list_len[15:8], pbyte} != 16'h0000)) begin
                next_r.fsm = FUCH_IDLE;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.status = ST_CHECK;
                next_r.sense_key = KEY_ILLEGAL;
                next_r.asc = ASC_CDB_FIELD;
                next_r.ascq = 8'h00;
              end else if (r.cdb[CDB_COMPLETE_LIST_FLAG]) begin
                glist_clr = 1'b1;
              end
            end
            3'h6: next_r.rem[15:8] = pbyte;
            HDR_LAST: begin
              next_r.desc_idx = '0;
              if ({r.rem[15:8], pbyte} != 16'h0000) begin
                next_r.fsm = FUCH_DOUT_PAT;
                next_r.rem = {r.rem[15:8], pbyte};
              end else if (r.list_len != 16'h0000) begin
                next_r.fsm = FUCH_DOUT_LIST;
                next_r.rem = r.list_len;
              end else begin
                next_r = start_fmt(next_r);
              end
            end
            default: begin
            end
          endcase
        end
        FUCH_DOUT_PAT: begin
          // the pattern is accepted but not stored
          next_r.rem = r.rem - 16'h0001;
          if (r.rem == 16'h0001) begin
            if (r.list_len != 16'h0000) begin
              next_r.fsm = FUCH_DOUT_LIST;
              next_r.rem = r.list_len;
            end else begin
              next_r = start_fmt(next_r);
            end
          end
        end
        FUCH_DOUT_LIST: begin
          next_r.desc_sh = {r.desc_sh[15:0], pbyte};
          next_r.desc_idx = r.desc_idx + 2'h1;
          next_r.rem = r.rem - 16'h0001;
          if (r.desc_idx == 2'h3) begin
            glist_add = 1'b1;
            glist_lba = {r.desc_sh, pbyte};
            if (err_now) begin
              next_r.fmt_err = 1'b1;
            end
          end
          if (r.rem == 16'h0001) begin
            next_r = start_fmt(next_r);
          end
        end
        FUCH_IDLE, FUCH_FORMAT: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign format_busy = r.busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_conflict_rejects;
    @(posedge pclk) disable iff (!presetn)
    go_now && (r.fsm == FUCH_IDLE) && (opcode == OP_FORMAT) && conflict
    |=> (r.status == ST_CONFLICT) && r.done && !r.busy;
  endproperty
  a_conflict_rejects: assert property (p_conflict_rejects) else $error("format not rejected on conflict");

  property p_other_in_format;
    @(posedge pclk) disable iff (!presetn)
    go_now && (r.fsm == FUCH_FORMAT) && (opcode != OP_INQUIRY) && (opcode != OP_REQ_SENSE)
    |=> r.done && (r.status == ($past(conflict) ? ST_CONFLICT : ST_CHECK));
  endproperty
  a_other_in_format: assert property (p_other_in_format) else $error("wrong status during format");

  property p_inquiry_in_format;
    @(posedge pclk) disable iff (!presetn)
    go_now && (r.fsm == FUCH_FORMAT) && (opcode == OP_INQUIRY)
    |=> r.inquiry_ok && (r.status == ST_GOOD) && r.done;
  endproperty
  a_inquiry_in_format: assert property (p_inquiry_in_format) else $error("inquiry refused during format");

  property p_sense_in_format;
    @(posedge pclk) disable iff (!presetn)
    go_now && (r.fsm == FUCH_FORMAT) && (opcode == OP_REQ_SENSE) && !r.fmt_err && !err_now
    |=> (r.sense_key == KEY_NOT_READY) && (r.asc == ASC_NOT_READY) && (r.ascq == ASCQ_FMT)
        && (r.sks == {$past(r.block), 10'h000});
  endproperty
  a_sense_in_format: assert property (p_sense_in_format) else $error("bad sense during format");

  property p_primary_not_grown;
    @(posedge pclk) disable iff (!presetn)
    glist_add && (r.fsm == FUCH_FORMAT) |-> !(pl_blk_hit && !r.opts[OPT_SKIP_PRIMARY]);
  endproperty
  a_primary_not_grown: assert property (p_primary_not_grown) else $error("primary defect copied");

  property p_cert_merged;
    @(posedge pclk) disable iff (!presetn)
    (r.fsm == FUCH_FORMAT) && certify_fail && !r.opts[OPT_SKIP_CERTIFY] && !pl_blk_hit
    |-> glist_add && (glist_lba[BLK_W-1:0] == r.block);
  endproperty
  a_cert_merged: assert property (p_cert_merged) else $error("certify defect not merged");

  property p_clear_needs_complete_list_flag;
    @(posedge pclk) disable iff (!presetn)
    glist_clr |-> r.cdb[CDB_COMPLETE_LIST_FLAG] && (r.fsm == FUCH_DOUT_HDR);
  endproperty
  a_clear_needs_complete_list_flag: assert property (p_clear_needs_complete_list_flag) else $error("grown list wrongly cleared");

  property p_no_data_no_dout;
    @(posedge pclk) disable iff (!presetn)
    go_now && (r.fsm == FUCH_IDLE) && (opcode == OP_FORMAT) && !conflict && !r.cdb[CDB_FORMAT_DATA_PRESENT]
    |=> (r.fsm == FUCH_FORMAT) && r.busy ##1 (r.fsm == FUCH_FORMAT);
  endproperty
  a_no_data_no_dout: assert property (p_no_data_no_dout) else $error("format without data stalled");

  property p_bad_option;
    @(posedge pclk) disable iff (!presetn)
    param_wr && (r.fsm == FUCH_DOUT_HDR) && (r.hdr_idx == 3'h3) && ((r.opts & ~OPT_SUPPORTED) != 8'h00)
    |=> (r.fsm == FUCH_IDLE) && (r.status == ST_CHECK) && (r.sense_key == KEY_ILLEGAL)
        && (r.asc == ASC_PARAM_FIELD);
  endproperty
  a_bad_option: assert property (p_bad_option) else $error("unsupported option accepted");

  property p_descriptor_added;
    @(posedge pclk) disable iff (!presetn)
    param_wr && (r.fsm == FUCH_DOUT_LIST) && (r.desc_idx == 2'h3)
    |-> glist_add && (glist_lba[7:0] == pbyte);
  endproperty
  a_descriptor_added: assert property (p_descriptor_added) else $error("descriptor not mapped out");

  property p_busy_ends_done;
    @(posedge pclk) disable iff (!presetn)
    $fell(r.busy) |-> r.done && (r.fsm == FUCH_IDLE);
  endproperty
  a_busy_ends_done: assert property (p_busy_ends_done) else $error("busy dropped without completion");

endmodule : fuch_format_unit

// ---- fuch_apb_init.sv ----
module fuch_apb_init (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [fuch_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import fuch_pkg::*;
  logic err = 1'b0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // ----------------------------------------
  // one transfer; entered just after an edge
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request held until pready is seen high at an edge; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never lands in this time step
    @(posedge pclk);
  endtask : xfer
endmodule : fuch_apb_init

// ---- format_unit_command_handler_tb.sv ----
module format_unit_command_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fuch_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic certify_fail = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, format_busy;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_errors = 0;
  int check_count = 0;
  always #12.5 pclk = ~pclk;
  fuch_format_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .certify_fail(certify_fail), .format_busy(format_busy));
  fuch_apb_init ini (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ini.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    ini.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e, s);
  endtask : rd
  task automatic cmd(input logic [31:0] lo, input logic [31:0] ctl);
    wr(OFS_CDB_LO, lo);
    wr(OFS_CTRL, ctl);
  endtask : cmd
  task automatic plist(input logic [7:0] b[]);
    foreach (b[i]) wr(OFS_PARAM, {24'h0, b[i]});
  endtask : plist
  task automatic query(input logic [31:0] lba, input logic [31:0] m, input logic [31:0] e);
    wr(OFS_QUERY, lba);
    rd(OFS_QUERY, m, e, "query");
  endtask : query
  task automatic wait_idle();
    int n;
    n = 0;
    while (format_busy !== 1'b0 && n < 400) begin
      n++;
      @(posedge pclk);
    end
  endtask : wait_idle
  initial begin
    #75000;
    n_errors++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_STATUS, 32'hffffffff, 32'h0, "reset status");
    rd(8'h40, 32'hffffffff, 32'h0, "unmapped");
    chk({31'h0, ini.err}, 32'h1, "slverr");
    cmd(32'h04, 32'h3);
    rd(OFS_STATUS, 32'h1ff, 32'h018, "reserved");
    cmd(32'h04, 32'h5);
    rd(OFS_STATUS, 32'h1ff, 32'h018, "extent");
    $display("test conflict done");
    cmd(32'h04, 32'h1);
    chk({31'h0, format_busy}, 32'h1, "busy");
    cmd(32'h12, 32'h1);
    rd(OFS_STATUS, 32'h4ff, 32'h400, "inquiry");
    cmd(32'h00, 32'h1);
    rd(OFS_STATUS, 32'hff, 32'h02, "other");
    cmd(32'h00, 32'h3);
    rd(OFS_STATUS, 32'hff, 32'h18, "other reserved");
    cmd(32'h03, 32'h1);
    rd(OFS_SENSE, 32'hffff0f, 32'h040402, "sense");
    wait_idle();
    rd(OFS_STATUS, 32'h3ff, 32'h200, "format end");
    $display("test plain format done");
    wr(OFS_REASSIGN, 32'h30);
    cmd(32'h1004, 32'h1);
    plist('{8'h00, 8'h80, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h21});
    wait_idle();
    query(32'h21, 32'h1, 32'h1);
    query(32'h30, 32'h1, 32'h1);
    query(32'h05, 32'h1f01, 32'h0201);
    $display("test list format done");
    cmd(32'h1004, 32'h1);
    plist('{8'h00, 8'h01, 8'h00, 8'h00});
    wait_idle();
    rd(OFS_STATUS, 32'h3ff, 32'h202, "bad option");
    rd(OFS_SENSE, 32'hff0f, 32'h2605, "bad option sense");
    $display("test bad option done");
    certify_fail <= 1'b1;
    cmd(32'h1804, 32'h1);
    plist('{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    wait_idle();
    certify_fail <= 1'b0;
    query(32'h30, 32'h1, 32'h0);
    query(32'h00, 32'h1f01, 32'h1001);
    $display("test complete list done");
    summarize();
  end
endmodule : format_unit_command_handler_tb
